/* rtl/startup_timing_config.sv */
`timescale 1ns/1ps
`include "startup_timing_config_consts.svh"
module startup_timing_config #(
  parameter logic [6:0]  DEV_ADDR  = 7'h24,            // arbitrary bus address
  parameter int          CYC_MS    = `CYC_PER_MS,      // clocks per millisecond
  parameter int          CYC_SHORT = `CYC_SHORT_DELAY  // clocks for the 50 us delay
) (
  input  wire logic                clk_sys,            // 125 MHz system clock
  input  wire logic                nrst,               // async reset, active low
  input  wire logic                scl,                // bus clock pin
  input  wire logic                sda_in,             // bus data pin level
  output wire logic                sda_out,            // bus data drive value
  output wire logic                sda_oe_n,           // low while pulling data low
  output wire logic                alert_out,          // alert drive value
  output wire logic                alert_oe_n,         // low while alert is asserted
  input  wire logic                start_req,          // start condition pin
  input  wire logic                ss_strap_en,        // soft-start strap detect pin
  input  wire logic [6:0]          ss_strap_mant,      // decoded strap mantissa pins
  input  wire logic [10:0]         overtemp_fault_threshold, // fault limit mantissa
  input  wire logic [6:0]          ramp_timeout_limit, // timeout limit mantissa
  input  wire logic                nv_restore_valid,   // restored values present
  input  wire logic [6:0]          nv_delay,           // restored delay mantissa
  input  wire logic [6:0]          nv_ramp,            // restored ramp mantissa
  output wire logic                nv_save,            // one-cycle store pulse
  output wire logic [6:0]          power_on_delay,     // delay mantissa register
  output wire logic [6:0]          output_ramp_time,   // ramp mantissa register
  output wire logic [10:0]         overtemp_warning_threshold, // warning mantissa
  output wire logic                comm_fault,         // summary cml flag
  output wire logic                invalid_data,       // comm status ivd flag
  output wire logic                delay_active,       // waiting power-on delay
  output wire logic                ramp_active,        // output ramp in progress
  output wire logic                output_on           // ramp complete
);

  startup_timing_config_pkg::state_t s;
  startup_timing_config_pkg::state_t next_s;
  logic                               commit;
  logic [15:0]                        wval;

  // ========================================================================
  // bucket mapping of a mantissa to effective milliseconds
  function automatic logic [6:0] eff_ms(input logic [6:0] m, input logic is_ramp);
    logic [6:0] r;
    r = 7'h64;
    if (m == 7'h00) r = is_ramp ? 7'h01 : 7'h00;
    else if (m <= 7'h06) r = m;
    else if (m <= 7'h09) r = 7'h07;
    else if (m <= 7'h0C) r = 7'h0A;
    else if (m <= 7'h11) r = 7'h0E;
    else if (m <= 7'h16) r = 7'h13;
    else if (m <= 7'h20) r = 7'h1B;
    else if (m <= 7'h2C) r = 7'h25;
    else if (m <= 7'h3E) r = 7'h34;
    else if (m <= 7'h56) r = 7'h48;
    return r;
  endfunction

  // readback word for a command, fixed bits read zero
  function automatic logic [15:0] rd_word(input startup_timing_config_pkg::state_t q);
    logic [15:0] w;
    w = 16'h0000;
    unique case (q.cmd)
      `CMD_WARN_LIMIT:  w = {5'h00, q.warn};
      `CMD_ON_DELAY:    w = {9'h000, q.dly};
      `CMD_RAMP_TIME:   w = {9'h000, q.ramp};
      `CMD_STATUS_SUM:  w = 16'(q.cml) << `STS_CML_BIT;
      `CMD_STATUS_COMM: w = 16'(q.ivd) << `COMM_IVD_BIT;
      default:          w = 16'h0000;
    endcase
    return w;
  endfunction

  // ========================================================================
  // next-state logic
  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       set_cml;
    logic       set_ivd;
    logic       clr;
    logic       seq_done;
    logic [15:0] rw_word;
    next_s    = s;
    commit    = 1'b0;
    wval      = 16'h0000;
    set_cml   = 1'b0;
    set_ivd   = 1'b0;
    clr       = 1'b0;
    rw_word   = rd_word(s);
    scl_rise  = s.scl_s & ~s.scl_p;
    scl_fall  = ~s.scl_s & s.scl_p;
    bus_start = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
    bus_stop  = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
    seq_done  = (s.cyc == `CYC_W'(1)) && (s.ms <= 7'h01);
    // two-flop synchronisers, then an edge copy
    next_s.scl_m   = scl;
    next_s.scl_s   = s.scl_m;
    next_s.scl_p   = s.scl_s;
    next_s.sda_m   = sda_in;
    next_s.sda_s   = s.sda_m;
    next_s.sda_p   = s.sda_s;
    next_s.go_m    = start_req;
    next_s.go_s    = s.go_m;
    next_s.strap_m = {ss_strap_en, ss_strap_mant};
    next_s.strap_s = s.strap_m;
    next_s.nv_save = 1'b0;

    // power-up load: restore, then strap, then derived warning default
    if (s.initc != 2'h3) begin
      next_s.initc = s.initc + 2'h1;
      if (s.initc == 2'h2) begin
        if (nv_restore_valid) begin
          next_s.dly  = nv_delay;
          next_s.ramp = nv_ramp;
        end
        if (s.strap_s[7]) next_s.ramp = s.strap_s[6:0];
        next_s.warn = (overtemp_fault_threshold >= `WARN_MIN + `WARN_OFFSET) ?
                      overtemp_fault_threshold - `WARN_OFFSET : `WARN_MIN;
      end
    end

    // serial slave
    if (bus_start) begin
      next_s.bst     = startup_timing_config_pkg::BUS_ADDR;
      next_s.bitc    = 4'h0;
      next_s.sda_drv = 1'b0;
    end else if (bus_stop) begin
      next_s.bst     = startup_timing_config_pkg::BUS_IDLE;
      next_s.sda_drv = 1'b0;
    end else if (scl_rise) begin
      unique case (s.bst)
        startup_timing_config_pkg::BUS_ADDR,
        startup_timing_config_pkg::BUS_RX: begin
          next_s.sh   = {s.sh[6:0], s.sda_s};
          next_s.bitc = s.bitc + 4'h1;
        end
        startup_timing_config_pkg::BUS_TX:   next_s.bitc = s.bitc + 4'h1;
        startup_timing_config_pkg::BUS_ACKT: next_s.rdi  = ~s.sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (s.bst)
        startup_timing_config_pkg::BUS_ADDR: begin
          if (s.bitc == 4'h8) begin
            if (s.sh[7:1] == DEV_ADDR) begin
              next_s.bst     = startup_timing_config_pkg::BUS_ACKA;
              next_s.sda_drv = 1'b1;
              next_s.rw      = s.sh[0];
            end else begin
              next_s.bst = startup_timing_config_pkg::BUS_IDLE;
            end
          end
        end
        startup_timing_config_pkg::BUS_ACKA: begin
          next_s.bitc = 4'h0;
          if (s.rw) begin
            next_s.bst     = startup_timing_config_pkg::BUS_TX;
            next_s.txb     = rw_word[7:0];
            next_s.sda_drv = ~rw_word[7];
            next_s.rdi     = 1'b0;
          end else begin
            next_s.bst     = startup_timing_config_pkg::BUS_RX;
            next_s.sda_drv = 1'b0;
            next_s.nb      = 2'h0;
          end
        end
        startup_timing_config_pkg::BUS_RX: begin
          if (s.bitc == 4'h8) begin
            next_s.bst     = startup_timing_config_pkg::BUS_ACKR;
            next_s.sda_drv = 1'b1;
            if (s.nb != 2'h3) next_s.nb = s.nb + 2'h1;
            unique case (s.nb)
              2'h0: begin
                next_s.cmd = s.sh;
                if (s.sh == `CMD_SAVE_ALL) next_s.nv_save = 1'b1;
                if (s.sh == `CMD_CLEAR_FAULTS) clr = 1'b1;
              end
              2'h1: next_s.lo = s.sh;
              2'h2: begin
                commit = 1'b1;
                wval   = {s.sh, s.lo};
              end
              default: ;
            endcase
          end
        end
        startup_timing_config_pkg::BUS_ACKR: begin
          next_s.bst     = startup_timing_config_pkg::BUS_RX;
          next_s.bitc    = 4'h0;
          next_s.sda_drv = 1'b0;
        end
        startup_timing_config_pkg::BUS_TX: begin
          if (s.bitc == 4'h8) begin
            next_s.bst     = startup_timing_config_pkg::BUS_ACKT;
            next_s.sda_drv = 1'b0;
          end else begin
            next_s.txb     = {s.txb[6:0], 1'b0};
            next_s.sda_drv = ~s.txb[6];
          end
        end
        startup_timing_config_pkg::BUS_ACKT: begin
          if (s.rdi) begin
            next_s.bst     = startup_timing_config_pkg::BUS_TX;
            next_s.bitc    = 4'h0;
            next_s.txb     = rw_word[15:8];
            next_s.sda_drv = ~rw_word[15];
          end else begin
            next_s.bst = startup_timing_config_pkg::BUS_IDLE;
          end
        end
        default: ;
      endcase
    end

    // register writes; exponent and upper mantissa bits are dropped
    if (commit) begin
      unique case (s.cmd)
        `CMD_WARN_LIMIT: begin
          if (wval[10:0] >= `WARN_MIN && wval[10:0] <= `WARN_MAX &&
              wval[10:0] < overtemp_fault_threshold) begin
            next_s.warn = wval[10:0];
          end else begin
            set_cml = 1'b1;
            set_ivd = 1'b1;
          end
        end
        `CMD_ON_DELAY: next_s.dly = wval[6:0];
        `CMD_RAMP_TIME: begin
          if (ramp_timeout_limit != 7'h00 && wval[6:0] > ramp_timeout_limit) begin
            set_cml = 1'b1;
            set_ivd = 1'b1;
          end else begin
            next_s.ramp = wval[6:0];
          end
        end
        default: set_cml = 1'b1;
      endcase
    end
    // a flag set in the same cycle as a clear survives
    next_s.cml = (s.cml & ~clr) | set_cml;
    next_s.ivd = (s.ivd & ~clr) | set_ivd;

    // start sequencer: delay, then ramp, then on
    if (s.cyc != `CYC_W'(0)) next_s.cyc = s.cyc - `CYC_W'(1);
    if (s.cyc == `CYC_W'(1) && s.ms > 7'h01) begin
      next_s.ms  = s.ms - 7'h01;
      next_s.cyc = `CYC_W'(CYC_MS);
    end
    if (!s.go_s) begin
      next_s.sst = startup_timing_config_pkg::SEQ_IDLE;
      next_s.cyc = `CYC_W'(0);
    end else begin
      unique case (s.sst)
        startup_timing_config_pkg::SEQ_IDLE: begin
          if (s.initc == 2'h3) begin
            next_s.sst = startup_timing_config_pkg::SEQ_DLY;
            next_s.ms  = eff_ms(s.dly, 1'b0);
            next_s.cyc = (s.dly == 7'h00) ? `CYC_W'(CYC_SHORT) : `CYC_W'(CYC_MS);
          end
        end
        startup_timing_config_pkg::SEQ_DLY: begin
          if (seq_done) begin
            next_s.sst = startup_timing_config_pkg::SEQ_RISE;
            next_s.ms  = eff_ms(s.ramp, 1'b1);
            next_s.cyc = `CYC_W'(CYC_MS);
          end
        end
        startup_timing_config_pkg::SEQ_RISE: begin
          if (seq_done) next_s.sst = startup_timing_config_pkg::SEQ_ON;
        end
        startup_timing_config_pkg::SEQ_ON: ;
      endcase
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s         <= '0;
      s.bst     <= startup_timing_config_pkg::BUS_IDLE;
      s.sst     <= startup_timing_config_pkg::SEQ_IDLE;
      s.dly     <= `RST_ON_DELAY;
      s.ramp    <= `RST_RAMP_TIME;
      s.warn    <= `RST_WARN;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // outputs
  assign sda_out      = 1'b0;
  assign sda_oe_n     = ~s.sda_drv;
  assign alert_out    = 1'b0;
  assign alert_oe_n   = ~s.cml;
  assign nv_save      = s.nv_save;
  assign power_on_delay             = s.dly;
  assign output_ramp_time           = s.ramp;
  assign overtemp_warning_threshold = s.warn;
  assign comm_fault   = s.cml;
  assign invalid_data = s.ivd;
  assign delay_active = (s.sst == startup_timing_config_pkg::SEQ_DLY);
  assign ramp_active  = (s.sst == startup_timing_config_pkg::SEQ_RISE);
  assign output_on    = (s.sst == startup_timing_config_pkg::SEQ_ON);

  // ========================================================================
  // checks
  a_warn_in_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit && s.cmd == `CMD_WARN_LIMIT && wval[10:0] < `WARN_MIN
    |=> s.cml && s.ivd && $stable(s.warn)) else $error("low warning limit accepted");
  a_ramp_reject: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit && s.cmd == `CMD_RAMP_TIME && ramp_timeout_limit != 7'h00 &&
    wval[6:0] > ramp_timeout_limit |=> s.cml && s.ivd && !alert_oe_n && $stable(s.ramp))
    else $error("ramp write over limit not rejected");
  a_ramp_nolimit: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit && s.cmd == `CMD_RAMP_TIME && ramp_timeout_limit == 7'h00
    |=> s.ramp == $past(wval[6:0])) else $error("ramp write dropped with zero limit");
  a_delay_store: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit && s.cmd == `CMD_ON_DELAY |=> s.dly == $past(wval[6:0]))
    else $error("delay write not stored");
  a_save_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
    s.bst == startup_timing_config_pkg::BUS_RX && s.nb == 2'h0 && s.bitc == 4'h8 &&
    ~s.scl_s && s.scl_p && s.sh == `CMD_SAVE_ALL && !(s.scl_s & s.scl_p)
    |=> nv_save ##1 !nv_save) else $error("save pulse wrong");
  a_delay_bucket: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(delay_active) |-> s.ms == eff_ms(s.dly, 1'b0) &&
    (s.dly == 7'h00 ? s.cyc == `CYC_W'(CYC_SHORT) : s.cyc == `CYC_W'(CYC_MS)))
    else $error("delay bucket wrong");
  a_ramp_bucket: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(ramp_active) |-> s.ms == eff_ms(s.ramp, 1'b1) && s.ms != 7'h00)
    else $error("ramp bucket wrong");
  a_order_seq: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(ramp_active) |-> $past(delay_active) && !output_on)
    else $error("ramp began without delay");
  a_readback_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    s.bst == startup_timing_config_pkg::BUS_ACKT && s.rdi && s.cmd == `CMD_ON_DELAY &&
    ~s.scl_s && s.scl_p |=> s.txb == 8'h00) else $error("fixed bits read nonzero");
  a_warn_bounds: assert property (@(posedge clk_sys) disable iff (!nrst)
    s.initc == 2'h3 && overtemp_fault_threshold <= 11'h0A5
    |-> s.warn >= `WARN_MIN && s.warn <= `WARN_MAX) else $error("warning out of range");

endmodule

/* rtl/startup_timing_config_consts.svh */
`ifndef STARTUP_TIMING_CONFIG_CONSTS_SVH
`define STARTUP_TIMING_CONFIG_CONSTS_SVH
// ==========================================================================
// command codes on the management bus
`define CMD_CLEAR_FAULTS  8'h03
`define CMD_SAVE_ALL      8'h11
`define CMD_WARN_LIMIT    8'h51
`define CMD_ON_DELAY      8'h60
`define CMD_RAMP_TIME     8'h61
`define CMD_STATUS_SUM    8'h78
`define CMD_STATUS_COMM   8'h7E
// ==========================================================================
// field positions and widths
`define STS_CML_BIT       3
`define COMM_IVD_BIT      6
`define MANT_W            7
`define WARN_W            11
`define CYC_W             20
// ==========================================================================
// reset values and warning limits
`define RST_ON_DELAY      7'h00
`define RST_RAMP_TIME     7'h05
`define RST_WARN          11'h064
`define WARN_MIN          11'h064
`define WARN_MAX          11'h08C
`define WARN_OFFSET       11'h019
// ==========================================================================
// timing in ns, and the clock counts derived from it
`define CLK_PERIOD_NS     8
`define MS_NS             1000000
`define SHORT_DELAY_NS    50000
`define CYC_PER_MS        (`MS_NS / `CLK_PERIOD_NS)
`define CYC_SHORT_DELAY   ((`SHORT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* rtl/startup_timing_config_pkg.sv */
`include "startup_timing_config_consts.svh"
package startup_timing_config_pkg;
  // ========================================================================
  // serial slave states, gray along the path
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_ADDR = 3'h1,
    BUS_ACKA = 3'h3,
    BUS_RX   = 3'h2,
    BUS_ACKR = 3'h6,
    BUS_TX   = 3'h7,
    BUS_ACKT = 3'h5
  } bus_state_t;

  // ========================================================================
  // start sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_DLY  = 2'h1,
    SEQ_RISE = 2'h3,
    SEQ_ON   = 2'h2
  } seq_state_t;

  // ========================================================================
  // whole state of the block
  typedef struct packed {
    logic                    scl_m;
    logic                    scl_s;
    logic                    scl_p;
    logic                    sda_m;
    logic                    sda_s;
    logic                    sda_p;
    logic                    go_m;
    logic                    go_s;
    logic [7:0]              strap_m;
    logic [7:0]              strap_s;
    logic [1:0]              initc;
    bus_state_t              bst;
    logic [3:0]              bitc;
    logic [7:0]              sh;
    logic [7:0]              txb;
    logic                    rw;
    logic [1:0]              nb;
    logic                    rdi;
    logic [7:0]              cmd;
    logic [7:0]              lo;
    logic                    sda_drv;
    logic [`MANT_W-1:0]      dly;
    logic [`MANT_W-1:0]      ramp;
    logic [`WARN_W-1:0]      warn;
    logic                    cml;
    logic                    ivd;
    logic                    nv_save;
    seq_state_t              sst;
    logic [`CYC_W-1:0]       cyc;
    logic [`MANT_W-1:0]      ms;
  } state_t;
endpackage

/* sim/pmbus_host_model.sv */
`timescale 1ns/1ps
// ========================================================================
// bus host: paces the bus clock from the system clock, only pulls data low
module pmbus_host_model #(
  parameter logic [6:0] ADDR = 7'h24 // device bus address
) (
  input  wire logic clk_sys, // pacing clock
  input  wire logic sda,     // resolved data line
  output logic      scl,     // bus clock, idles high
  output logic      sda_low  // high while the host pulls data low
);
  // bus idles released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // a quarter of the bus clock period
  task automatic q();
    repeat (4) @(posedge clk_sys);
  endtask
  // one bit, line level sampled in the middle of the high phase
  task automatic xbit(input logic b, output logic got);
    sda_low <= ~b;
    q();
    scl <= 1'b1;
    q();
    got = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // start and repeated start: data falls while the clock is high
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], g);
    end
    xbit(1'b1, g);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(last, g);
  endtask
  // word write low byte first, or the command alone when n_data is 0
  task automatic write(input logic [7:0] cmd, input logic [15:0] w, input int n_data);
    start();
    wbyte({ADDR, 1'b0});
    wbyte(cmd);
    if (n_data > 0) begin
      wbyte(w[7:0]);
      wbyte(w[15:8]);
    end
    stop();
  endtask
  task automatic read(input logic [7:0] cmd, output logic [15:0] w);
    start();
    wbyte({ADDR, 1'b0});
    wbyte(cmd);
    start();
    wbyte({ADDR, 1'b1});
    rbyte(1'b0, w[7:0]);
    rbyte(1'b1, w[15:8]);
    stop();
  endtask
endmodule

/* sim/startup_timing_config_tb.sv */
`timescale 1ns/1ps
`include "startup_timing_config_consts.svh"
// ========================================================================
// self-checking bench for the start-up timing registers
module startup_timing_config_tb;
  localparam int CYC_MS    = 20;
  localparam int CYC_SHORT = 3;
  logic        clk_sys, nrst, start_req, ss_strap_en, nv_restore_valid, scl, sda_low, e_err;
  logic [6:0]  ss_strap_mant, ramp_timeout_limit, nv_delay, nv_ramp;
  logic [10:0] overtemp_fault_threshold;
  wire         sda, sda_out, sda_oe_n, alert_out, alert_oe_n, nv_save;
  wire  [6:0]  power_on_delay, output_ramp_time;
  wire  [10:0] overtemp_warning_threshold;
  wire         comm_fault, invalid_data, delay_active, ramp_active, output_on;
  int          error_cnt = 0, comparisons = 0, save_cnt = 0, lim, r;
  int          dv[5] = '{0, 7, 9, 86, 87};
  int          rv[5] = '{0, 1, 12, 13, 127};

  startup_timing_config #(.CYC_MS(CYC_MS), .CYC_SHORT(CYC_SHORT)) u_startup_timing_config (
    .clk_sys, .nrst, .scl, .sda_in(sda), .sda_out, .sda_oe_n, .alert_out, .alert_oe_n,
    .start_req, .ss_strap_en, .ss_strap_mant, .overtemp_fault_threshold,
    .ramp_timeout_limit, .nv_restore_valid, .nv_delay, .nv_ramp, .nv_save, .power_on_delay,
    .output_ramp_time, .overtemp_warning_threshold, .comm_fault, .invalid_data,
    .delay_active, .ramp_active, .output_on);
  pmbus_host_model u_pmbus_host_model (.clk_sys, .sda, .scl, .sda_low);

  // open-drain data line with pull-up
  assign sda = ~sda_low & (sda_oe_n | sda_out);
  always #4 clk_sys = ~clk_sys;
  // count store pulses
  always @(posedge clk_sys) if (nv_save === 1'b1) save_cnt <= save_cnt + 1;

  // ======================================================================
  // checking and bus helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] msk, input logic [15:0] exp);
    logic [15:0] w;
    u_pmbus_host_model.read(cmd, w);
    chk(w & msk, exp);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
    u_pmbus_host_model.write(cmd, w, 1);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic flags();
    rd(`CMD_STATUS_SUM, 16'h0008, {12'h000, e_err, 3'h0});
    rd(`CMD_STATUS_COMM, 16'h0040, {9'h000, e_err, 6'h00});
    chk({12'h0, alert_out, comm_fault, invalid_data, alert_oe_n},
        {12'h0, 1'b0, e_err, e_err, ~e_err});
  endtask
  task automatic clear();
    u_pmbus_host_model.write(`CMD_CLEAR_FAULTS, 16'h0000, 0);
    e_err = 1'b0;
    flags();
  endtask
  // model: effective milliseconds of a mantissa bucket
  function automatic int eff(input int m);
    int lim_t[8] = '{9, 12, 17, 22, 32, 44, 62, 86};
    int val_t[8] = '{7, 10, 14, 19, 27, 37, 52, 72};
    if (m <= 6) return m;
    for (int i = 0; i < 8; i++) if (m <= lim_t[i]) return val_t[i];
    return 100;
  endfunction
  // one start: measure delay and ramp phases in clocks
  task automatic run_seq(input int d, input int rm);
    int n;
    wr(`CMD_ON_DELAY, 16'(d));
    wr(`CMD_RAMP_TIME, 16'(rm));
    start_req <= 1'b1;
    n = 0;
    while (delay_active !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      results();
    end
    n = 0;
    while (delay_active === 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(16'(n), 16'(d == 0 ? CYC_SHORT : eff(d) * CYC_MS));
    n = 0;
    while (ramp_active === 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(16'(n), 16'(eff(rm == 0 ? 1 : rm) * CYC_MS));
    chk({15'h0, output_on}, 16'h0001);
    if (n == 3000) results();
    start_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic reset_dut();
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ======================================================================
  // main sequence
  initial begin
    {clk_sys, nrst, start_req, ss_strap_en, nv_restore_valid, e_err} = 6'h00;
    {ss_strap_mant, ramp_timeout_limit, nv_delay, nv_ramp} = 28'h0;
    overtemp_fault_threshold = 11'h082;
    void'($urandom(32'h3311));
    reset_dut();
    rd(`CMD_ON_DELAY, 16'hFFFF, 16'h0000);
    rd(`CMD_RAMP_TIME, 16'hFFFF, 16'h0005);
    rd(`CMD_WARN_LIMIT, 16'hFFFF, 16'h0069);
    r = $urandom % 128;
    wr(`CMD_ON_DELAY, 16'hFF80 | 16'(r));
    rd(`CMD_ON_DELAY, 16'hFFFF, 16'(r));
    chk({9'h000, power_on_delay}, 16'(r));
    // ramp above the timeout limit is refused, equal is taken
    lim = 10 + $urandom % 71;
    ramp_timeout_limit <= 7'(lim);
    wr(`CMD_RAMP_TIME, 16'(lim + 1));
    e_err = 1'b1;
    flags();
    rd(`CMD_RAMP_TIME, 16'hFFFF, 16'h0005);
    clear();
    wr(`CMD_RAMP_TIME, 16'(lim));
    chk({9'h000, output_ramp_time}, 16'(lim));
    ramp_timeout_limit <= 7'h00;
    wr(`CMD_RAMP_TIME, 16'h007F);
    chk({9'h000, output_ramp_time}, 16'h007F);
    flags();
    // warning range with the fault limit at 150
    overtemp_fault_threshold <= 11'h096;
    wr(`CMD_WARN_LIMIT, 16'h008D);
    wr(`CMD_WARN_LIMIT, 16'h0063);
    e_err = 1'b1;
    flags();
    chk({5'h00, overtemp_warning_threshold}, 16'h0069);
    clear();
    wr(`CMD_WARN_LIMIT, 16'hF88C);
    rd(`CMD_WARN_LIMIT, 16'hFFFF, 16'h008C);
    u_pmbus_host_model.write(`CMD_SAVE_ALL, 16'h0000, 0);
    repeat (2) @(posedge clk_sys);
    chk(16'(save_cnt), 16'h0001);
    foreach (dv[i]) run_seq(dv[i], rv[i]);
    run_seq($urandom % 128, $urandom % 128);
    // restored values, strap override and low fault limit
    nv_restore_valid <= 1'b1;
    nv_delay <= 7'($urandom);
    nv_ramp <= 7'($urandom);
    ss_strap_en <= 1'b1;
    ss_strap_mant <= 7'($urandom);
    overtemp_fault_threshold <= 11'h078;
    reset_dut();
    chk({9'h000, power_on_delay}, {9'h000, nv_delay});
    chk({9'h000, output_ramp_time}, {9'h000, ss_strap_mant});
    chk({5'h00, overtemp_warning_threshold}, 16'h0064);
    results();
  end
endmodule
